// [shared/dspt_pkg.sv]
// package for the dual-slope pwm timer: register map, field layout and mode codes
`default_nettype none
package dspt_pkg;
   localparam logic [7:0]  ADDR_CONTROL_A  = 8'h80;
   localparam logic [7:0]  ADDR_CONTROL_B  = 8'h84;
   localparam logic [7:0]  ADDR_COUNT      = 8'h88;
   localparam logic [7:0]  ADDR_CMP_A      = 8'h8c;
   localparam logic [7:0]  ADDR_CMP_B      = 8'h90;
   localparam logic [7:0]  ADDR_CAPTURE    = 8'h94;
   localparam logic [7:0]  CONTROL_A_RESET = 8'h00;
   localparam logic [7:0]  CONTROL_B_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET      = 16'h0000;
   localparam logic [15:0] BOTTOM          = 16'h0000;
   localparam logic [15:0] MIN_TOP         = 16'h0003;
   localparam int          A_MODE_HI = 7;
   localparam int          A_MODE_LO = 6;
   localparam int          B_MODE_HI = 5;
   localparam int          B_MODE_LO = 4;
   localparam int          WGM_LO_HI = 1;
   localparam int          WGM_LO_LO = 0;
   localparam int          WGM_HI_HI = 4;
   localparam int          WGM_HI_LO = 3;
   localparam int          CS_HI     = 2;
   localparam int          CS_LO     = 0;
   localparam logic [7:0]  CONTROL_A_MASK = 8'hf3;
   localparam logic [7:0]  CONTROL_B_MASK = 8'h1f;
   // waveform modes kept by this block; WGM_CTC_CAP counts as WGM_NORMAL
   localparam logic [3:0] WGM_NORMAL   = 4'h0;
   localparam logic [3:0] WGM_PC8      = 4'h1;
   localparam logic [3:0] WGM_PC9      = 4'h2;
   localparam logic [3:0] WGM_PC10     = 4'h3;
   localparam logic [3:0] WGM_CTC_A    = 4'h4;
   localparam logic [3:0] WGM_PFC_CAP  = 4'h8;
   localparam logic [3:0] WGM_PFC_A    = 4'h9;
   localparam logic [3:0] WGM_PC_CAP   = 4'ha;
   localparam logic [3:0] WGM_PC_A     = 4'hb;
   localparam logic [3:0] WGM_CTC_CAP  = 4'hc;
   localparam logic [15:0] TOP_8BIT    = 16'h00ff;
   localparam logic [15:0] TOP_9BIT    = 16'h01ff;
   localparam logic [15:0] TOP_10BIT   = 16'h03ff;
   localparam logic [15:0] TOP_MAX     = 16'hffff;
   // output modes
   localparam logic [1:0] OM_OFF    = 2'h0;
   localparam logic [1:0] OM_TOGGLE = 2'h1;
   localparam logic [1:0] OM_CLEAR  = 2'h2;
   localparam logic [1:0] OM_SET    = 2'h3;
   // prescaler terminal counts (divide minus one)
   localparam logic [9:0] DIV8_LAST    = 10'h007;
   localparam logic [9:0] DIV64_LAST   = 10'h03f;
   localparam logic [9:0] DIV256_LAST  = 10'h0ff;
   localparam logic [9:0] DIV1024_LAST = 10'h3ff;
   localparam logic [2:0] CS_STOP    = 3'h0;
   localparam logic [2:0] CS_DIV1    = 3'h1;
   localparam logic [2:0] CS_DIV8    = 3'h2;
   localparam logic [2:0] CS_DIV64   = 3'h3;
   localparam logic [2:0] CS_DIV256  = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   typedef enum logic [1:0] {
      DSPT_PH_IDLE = 2'b00,
      DSPT_PH_DATA = 2'b01
   } dspt_phase_t;
   typedef struct packed {
      logic [7:0] addr;
      logic       write;
      logic       valid;
   } dspt_req_t;
   typedef struct packed {
      logic [15:0] cmp_a;
      logic [15:0] cmp_b;
   } dspt_cmp_t;
endpackage
`default_nettype wire

// [rtl/dspt_timer.sv]
// dual-slope pwm timer with ahb-lite register slave
//
// Chosen here: the AHB-Lite interface to the registers.
`default_nettype none
module dspt_timer (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        clk_en,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             chan_a_wave_out,
   output logic             chan_b_wave_out,
   output logic             chan_a_override,
   output logic             chan_b_override
);
   logic [7:0]           timer16_control_a;
   logic [7:0]           control_b;
   logic [15:0]          count_value;
   logic                 count_down;
   dspt_pkg::dspt_cmp_t  cmp_buf;
   dspt_pkg::dspt_cmp_t  cmp_act;
   logic [15:0]          capture_top_value;
   logic [9:0]           presc;
   logic [1:0]           wave;
   dspt_pkg::dspt_req_t  req;
   logic [31:0]          rdata;

   logic [7:0]           next_timer16_control_a;
   logic [7:0]           next_control_b;
   logic [15:0]          next_count_value;
   logic                 next_count_down;
   dspt_pkg::dspt_cmp_t  next_cmp_buf;
   dspt_pkg::dspt_cmp_t  next_cmp_act;
   logic [15:0]          next_capture_top_value;
   logic [9:0]           next_presc;
   logic [1:0]           next_wave;
   dspt_pkg::dspt_req_t  next_req;
   logic [31:0]          next_rdata;

   logic [3:0]  waveform_mode_sel;
   logic [2:0]  clk_sel;
   logic [1:0]  chan_a_output_mode;
   logic [1:0]  chan_b_output_mode;
   logic        tick;
   logic [15:0] top;
   logic        is_pc;
   logic        is_pfc;
   logic        dual;
   logic        top_from_a;
   logic        at_top;
   logic        at_bottom;
   logic        wr;
   logic [1:0]  omode [2];
   logic [15:0] cmpv  [2];

   assign chan_a_output_mode = timer16_control_a[dspt_pkg::A_MODE_HI:dspt_pkg::A_MODE_LO];
   assign chan_b_output_mode = timer16_control_a[dspt_pkg::B_MODE_HI:dspt_pkg::B_MODE_LO];
   assign waveform_mode_sel  = {control_b[dspt_pkg::WGM_HI_HI:dspt_pkg::WGM_HI_LO],
                                timer16_control_a[dspt_pkg::WGM_LO_HI:dspt_pkg::WGM_LO_LO]};
   assign clk_sel            = control_b[dspt_pkg::CS_HI:dspt_pkg::CS_LO];
   assign omode[0] = chan_a_output_mode;
   assign omode[1] = chan_b_output_mode;
   assign cmpv[0]  = cmp_act.cmp_a;
   assign cmpv[1]  = cmp_act.cmp_b;

   // waveform mode decode
   always_comb begin
      is_pc      = 1'b0;
      is_pfc     = 1'b0;
      top_from_a = 1'b0;
      case (waveform_mode_sel)
         dspt_pkg::WGM_PC8:     begin is_pc = 1'b1; top = dspt_pkg::TOP_8BIT; end
         dspt_pkg::WGM_PC9:     begin is_pc = 1'b1; top = dspt_pkg::TOP_9BIT; end
         dspt_pkg::WGM_PC10:    begin is_pc = 1'b1; top = dspt_pkg::TOP_10BIT; end
         dspt_pkg::WGM_PC_CAP:  begin is_pc = 1'b1; top = capture_top_value; end
         dspt_pkg::WGM_PC_A:    begin is_pc = 1'b1; top_from_a = 1'b1; top = cmp_act.cmp_a; end
         dspt_pkg::WGM_PFC_CAP: begin is_pfc = 1'b1; top = capture_top_value; end
         dspt_pkg::WGM_PFC_A:   begin is_pfc = 1'b1; top_from_a = 1'b1; top = cmp_act.cmp_a; end
         dspt_pkg::WGM_CTC_A:   begin top_from_a = 1'b1; top = cmp_act.cmp_a; end
         dspt_pkg::WGM_CTC_CAP: top = capture_top_value;
         default:               top = dspt_pkg::TOP_MAX;
      endcase
   end
   assign dual      = is_pc | is_pfc;
   assign at_top    = (count_value >= top);
   assign at_bottom = (count_value == dspt_pkg::BOTTOM);

   // prescaler
   always_comb begin
      next_presc = presc + 10'h001;
      case (clk_sel)
         dspt_pkg::CS_DIV1:    tick = 1'b1;
         dspt_pkg::CS_DIV8:    tick = (presc[2:0] == dspt_pkg::DIV8_LAST[2:0]);
         dspt_pkg::CS_DIV64:   tick = (presc[5:0] == dspt_pkg::DIV64_LAST[5:0]);
         dspt_pkg::CS_DIV256:  tick = (presc[7:0] == dspt_pkg::DIV256_LAST[7:0]);
         dspt_pkg::CS_DIV1024: tick = (presc == dspt_pkg::DIV1024_LAST);
         default:              begin tick = 1'b0; next_presc = 10'h000; end
      endcase
   end

   // counter, compare buffering and waveform
   always_comb begin
      next_count_value = count_value;
      next_count_down  = count_down;
      next_cmp_act     = cmp_act;
      if (tick) begin
         if (dual) begin
            if (!count_down) begin
               if (at_top) begin
                  next_count_down  = 1'b1;
                  next_count_value = count_value - 16'h0001;
               end else begin
                  next_count_value = count_value + 16'h0001;
               end
            end else if (at_bottom) begin
               next_count_down  = 1'b0;
               next_count_value = count_value + 16'h0001;
            end else begin
               next_count_value = count_value - 16'h0001;
            end
            // phase correct reloads at top, so a top change skews the slopes
            if (is_pc && at_top) next_cmp_act = cmp_buf;
            // bottom reload keeps both slopes of a period equal
            if (is_pfc && at_bottom) next_cmp_act = cmp_buf;
         end else begin
            next_count_down  = 1'b0;
            next_count_value = (top_from_a && at_top) || (count_value == dspt_pkg::TOP_MAX) ?
                               dspt_pkg::BOTTOM : count_value + 16'h0001;
            next_cmp_act     = cmp_buf; // non-pwm modes are not buffered
         end
      end
      if (wr && req.addr == dspt_pkg::ADDR_COUNT) next_count_value = hwdata[15:0];
   end

   for (genvar c = 0; c < 2; c++) begin : g_chan
      always_comb begin
         logic hit;
         hit = tick && (count_value == cmpv[c]);
         next_wave[c] = wave[c];
         if (dual) begin
            if (omode[c] == dspt_pkg::OM_TOGGLE) begin
               if (c == 0 && top_from_a && hit && is_pc) next_wave[c] = ~wave[c];
            // levels move only on a timer tick, so a stopped timer holds its pins during setup
            end else if (omode[c][1] && tick) begin
               // up match clears, down match sets in non-inverting; top holds high, bottom low
               if (cmpv[c] == dspt_pkg::BOTTOM) next_wave[c] = omode[c][0];
               else if (cmpv[c] >= top) next_wave[c] = ~omode[c][0];
               else if (hit) next_wave[c] = count_down ^ omode[c][0];
            end
         end else if (hit) begin
            case (omode[c])
               dspt_pkg::OM_TOGGLE: next_wave[c] = ~wave[c];
               dspt_pkg::OM_CLEAR:  next_wave[c] = 1'b0;
               dspt_pkg::OM_SET:    next_wave[c] = 1'b1;
               default:             next_wave[c] = wave[c];
            endcase
         end
      end
   end

   assign chan_a_wave_out = wave[0];
   assign chan_b_wave_out = wave[1];
   assign chan_a_override = |chan_a_output_mode;
   assign chan_b_override = |chan_b_output_mode;

   // ahb-lite slave, zero wait states, always okay
   assign wr        = req.valid & req.write;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata;

   always_comb begin
      next_req.valid = hsel & hready & htrans[1];
      next_req.write = hwrite;
      next_req.addr  = haddr[7:0];
      next_timer16_control_a = timer16_control_a;
      next_control_b         = control_b;
      next_cmp_buf           = cmp_buf;
      next_capture_top_value = capture_top_value;
      if (wr) begin
         case (req.addr)
            dspt_pkg::ADDR_CONTROL_A: next_timer16_control_a = hwdata[7:0] & dspt_pkg::CONTROL_A_MASK;
            dspt_pkg::ADDR_CONTROL_B: next_control_b = hwdata[7:0] & dspt_pkg::CONTROL_B_MASK;
            dspt_pkg::ADDR_CMP_A:     next_cmp_buf.cmp_a = hwdata[15:0];
            dspt_pkg::ADDR_CMP_B:     next_cmp_buf.cmp_b = hwdata[15:0];
            dspt_pkg::ADDR_CAPTURE:   next_capture_top_value = hwdata[15:0];
            default:                  next_capture_top_value = capture_top_value;
         endcase
      end
      next_rdata = 32'h0000_0000;
      // next values, so a read right behind a write sees the word that lands on the same edge
      if (next_req.valid && !hwrite) begin
         case (haddr[7:0])
            dspt_pkg::ADDR_CONTROL_A: next_rdata = {24'h000000, next_timer16_control_a};
            dspt_pkg::ADDR_CONTROL_B: next_rdata = {24'h000000, next_control_b};
            dspt_pkg::ADDR_COUNT:     next_rdata = {16'h0000, next_count_value};
            dspt_pkg::ADDR_CMP_A:     next_rdata = {16'h0000, next_cmp_buf.cmp_a};
            dspt_pkg::ADDR_CMP_B:     next_rdata = {16'h0000, next_cmp_buf.cmp_b};
            dspt_pkg::ADDR_CAPTURE:   next_rdata = {16'h0000, next_capture_top_value};
            default:                  next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer16_control_a <= dspt_pkg::CONTROL_A_RESET;
         control_b         <= dspt_pkg::CONTROL_B_RESET;
         count_value       <= dspt_pkg::WORD_RESET;
         count_down        <= 1'b0;
         cmp_buf           <= '0;
         cmp_act           <= '0;
         capture_top_value <= dspt_pkg::WORD_RESET;
         presc             <= 10'h000;
         wave              <= 2'h0;
         req               <= '0;
         rdata             <= 32'h0000_0000;
      end else if (clk_en) begin
         timer16_control_a <= next_timer16_control_a;
         control_b         <= next_control_b;
         count_value       <= next_count_value;
         count_down        <= next_count_down;
         cmp_buf           <= next_cmp_buf;
         cmp_act           <= next_cmp_act;
         capture_top_value <= next_capture_top_value;
         presc             <= next_presc;
         wave              <= next_wave;
         req               <= next_req;
         rdata             <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// [testbench/dspt_timer_properties.sv]
// checker: bus answers, control register shadow and output properties of the pwm timer
`default_nettype none
module dspt_timer_properties (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        clk_en,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        chan_a_wave_out,
   input wire logic        chan_b_wave_out,
   input wire logic        chan_a_override,
   input wire logic        chan_b_override
);
   logic       take;
   logic       ph_v;
   logic       ph_w;
   logic [7:0] ph_a;
   logic [7:0] sh_a;
   logic [7:0] sh_b;
   assign take = hsel & hready & htrans[1] & clk_en;
   // shadows follow the data phase, so they change on the same edge as the real registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_v <= 1'b0;
         ph_w <= 1'b0;
         ph_a <= 8'h00;
         sh_a <= 8'h00;
         sh_b <= 8'h00;
      end else if (clk_en) begin
         ph_v <= take;
         ph_w <= hwrite;
         ph_a <= haddr[7:0];
         if (ph_v && ph_w && ph_a == dspt_pkg::ADDR_CONTROL_A) sh_a <= hwdata[7:0] & dspt_pkg::CONTROL_A_MASK;
         if (ph_v && ph_w && ph_a == dspt_pkg::ADDR_CONTROL_B) sh_b <= hwdata[7:0] & dspt_pkg::CONTROL_B_MASK;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_ready; hreadyout == 1'b1; endproperty
   property p_okay; hresp == 1'b0; endproperty
   property p_ovr_a; chan_a_override == (sh_a[7:6] != 2'h0); endproperty
   property p_ovr_b; chan_b_override == (sh_a[5:4] != 2'h0); endproperty
   property p_rd_a; take && !hwrite && haddr[7:0] == dspt_pkg::ADDR_CONTROL_A |=> hrdata == {24'h000000, sh_a}; endproperty
   property p_rd_none; take && !hwrite && haddr[7:0] == 8'ha0 |=> hrdata == 32'h00000000; endproperty
   // four samples leave room for a tick that landed just before the stop
   property p_stop_a; (sh_b[2:0] == dspt_pkg::CS_STOP) [*4] |-> $stable(chan_a_wave_out); endproperty
   property p_stop_b; (sh_b[2:0] == dspt_pkg::CS_STOP) [*4] |-> $stable(chan_b_wave_out); endproperty
   a_ready: assert property (p_ready) else $error("hreadyout low");
   a_okay: assert property (p_okay) else $error("hresp not okay");
   a_ovr_a: assert property (p_ovr_a) else $error("channel a override wrong");
   a_ovr_b: assert property (p_ovr_b) else $error("channel b override wrong");
   a_rd_a: assert property (p_rd_a) else $error("control a read wrong");
   a_rd_none: assert property (p_rd_none) else $error("unmapped read not zero");
   a_stop_a: assert property (p_stop_a) else $error("channel a moved while stopped");
   a_stop_b: assert property (p_stop_b) else $error("channel b moved while stopped");
   c_wr_a: cover property (take && hwrite && haddr[7:0] == dspt_pkg::ADDR_CONTROL_A);
   c_rise_a: cover property ($rose(chan_a_wave_out));
   c_rise_b: cover property ($rose(chan_b_wave_out));
endmodule
bind dspt_timer dspt_timer_properties i_dspt_timer_properties (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .chan_a_wave_out(chan_a_wave_out),
   .chan_b_wave_out(chan_b_wave_out), .chan_a_override(chan_a_override), .chan_b_override(chan_b_override));
`default_nettype wire

// [testbench/dspt_load.sv]
// model of the load: two output-compare pins with pull-ups and their direction bits
`default_nettype none
module dspt_load (
   input  wire logic wave_a,
   input  wire logic wave_b,
   input  wire logic ovr_a,
   input  wire logic ovr_b,
   input  wire logic dir_a,
   input  wire logic dir_b,
   input  wire logic port_a,
   input  wire logic port_b,
   output logic      pin_a,
   output logic      pin_b
);
   // an undriven pin goes to its pull-up instead of keeping the last level
   assign pin_a = dir_a ? (ovr_a ? wave_a : port_a) : 1'b1;
   assign pin_b = dir_b ? (ovr_b ? wave_b : port_b) : 1'b1;
endmodule
`default_nettype wire

// [testbench/tb_dual_slope_pwm_timer16.sv]
// testbench: register access and pwm waveforms of the dual-slope timer
`default_nettype none
module tb_dual_slope_pwm_timer16;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        clk_en = 1'b1;
   logic [31:0] hrdata, rd;
   logic        hreadyout, hresp, wa, wb, oa, ob, pin_a, pin_b;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          div[5] = '{1, 8, 64, 256, 1024};
   always #4 hclk = ~hclk;
   dspt_timer i_dspt_timer (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .chan_a_wave_out(wa), .chan_b_wave_out(wb), .chan_a_override(oa),
      .chan_b_override(ob));
   dspt_load i_dspt_load (.wave_a(wa), .wave_b(wb), .ovr_a(oa), .ovr_b(ob), .dir_a(1'b1), .dir_b(1'b1),
      .port_a(1'b1), .port_b(1'b1), .pin_a(pin_a), .pin_b(pin_b));
   task report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   // the prescaler is stopped first so every register lands before the counter moves
   task cfg(input logic [3:0] m, input logic [1:0] ma, mb, input logic [15:0] top, ca, cb, input logic [2:0] cs);
      bus(1'b1, dspt_pkg::ADDR_CONTROL_B, 32'h0);
      bus(1'b1, dspt_pkg::ADDR_COUNT, 32'h0);
      bus(1'b1, dspt_pkg::ADDR_CAPTURE, {16'h0, top});
      bus(1'b1, dspt_pkg::ADDR_CMP_A, {16'h0, ca});
      bus(1'b1, dspt_pkg::ADDR_CMP_B, {16'h0, cb});
      bus(1'b1, dspt_pkg::ADDR_CONTROL_A, {24'h0, ma, mb, 2'h0, m[1:0]});
      bus(1'b1, dspt_pkg::ADDR_CONTROL_B, {27'h0, m[3:2], cs});
   endtask
   function automatic logic pin(input logic s);
      return s ? pin_b : pin_a;
   endfunction
   // skips to the second rising edge, then counts the high and the low part of the period that starts there
   task measure(input logic s, input int hi, input int lo);
      int c;
      repeat (2) begin
         c = 0;
         while (pin(s) !== 1'b0 && c < 9000) begin @(posedge hclk); c++; end
         c = 0;
         while (pin(s) !== 1'b1 && c < 9000) begin @(posedge hclk); c++; end
      end
      c = 0;
      while (pin(s) === 1'b1 && c < 9000) begin @(posedge hclk); c++; end
      check(32'(c), 32'(hi));
      c = 0;
      while (pin(s) === 1'b0 && c < 9000) begin @(posedge hclk); c++; end
      check(32'(c), 32'(lo));
   endtask
   task hold(input logic s, input logic lvl);
      int c;
      c = 0;
      repeat (30) @(posedge hclk);
      repeat (60) begin @(posedge hclk); if (pin(s) !== lvl) c++; end
      check(32'(c), 32'h0);
   endtask
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, dspt_pkg::ADDR_CONTROL_A, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, dspt_pkg::ADDR_CONTROL_A, 32'hff);
      bus(1'b0, dspt_pkg::ADDR_CONTROL_A, 32'h0);
      check(rd, 32'hf3);
      check({30'h0, oa, ob}, 32'h3);
      bus(1'b0, 8'ha0, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, dspt_pkg::ADDR_CONTROL_A, 32'h0);
      // one more edge so the write has landed; the port level differs from the idle wave
      @(posedge hclk);
      check({31'h0, pin_a}, 32'h1);
      bus(1'b1, dspt_pkg::ADDR_CMP_A, 32'h1234);
      bus(1'b0, dspt_pkg::ADDR_CMP_A, 32'h0);
      check(rd, 32'h1234);
      for (int i = 0; i < 5; i++) begin
         cfg(4'h8, 2'h3, 2'h2, 16'h3, 16'h1, 16'h1, 3'(i + 1));
         measure(1'b1, 2 * div[i], 4 * div[i]);
         measure(1'b0, 4 * div[i], 2 * div[i]);
      end
      cfg(4'ha, 2'h2, 2'h3, 16'h5, 16'h2, 16'h2, 3'h1);
      measure(1'b0, 4, 6);
      measure(1'b1, 6, 4);
      cfg(4'ha, 2'h2, 2'h3, 16'h5, 16'h0, 16'h5, 3'h1);
      hold(1'b0, 1'b0);
      hold(1'b1, 1'b0);
      cfg(4'ha, 2'h2, 2'h3, 16'h5, 16'h5, 16'h0, 3'h1);
      hold(1'b0, 1'b1);
      hold(1'b1, 1'b1);
      cfg(4'hb, 2'h1, 2'h0, 16'h0, 16'h3, 16'h0, 3'h1);
      measure(1'b0, 6, 6);
      cfg(4'h4, 2'h1, 2'h2, 16'h0, 16'h4, 16'h2, 3'h1);
      measure(1'b0, 5, 5);
      clk_en <= 1'b0;
      @(posedge hclk);
      hold(1'b0, pin_a);
      clk_en <= 1'b1;
      hold(1'b1, 1'b0);
      cfg(4'h4, 2'h1, 2'h3, 16'h0, 16'h4, 16'h2, 3'h1);
      hold(1'b1, 1'b1);
      // top moved while running: bottom reload in one mode, top reload in the other
      cfg(4'h9, 2'h0, 2'h2, 16'h0, 16'h3, 16'h1, 3'h1);
      bus(1'b1, dspt_pkg::ADDR_CMP_A, 32'h5);
      measure(1'b1, 2, 8);
      cfg(4'hb, 2'h0, 2'h2, 16'h0, 16'h3, 16'h1, 3'h1);
      bus(1'b1, dspt_pkg::ADDR_CMP_A, 32'h5);
      measure(1'b1, 2, 8);
      report_and_stop();
   end
   initial begin
      repeat (90000) @(posedge hclk);
      n_mismatch++;
      report_and_stop();
   end
endmodule
`default_nettype wire
